// file: logic/rev_event_status.sv
// event flag and live status registers of a dual converter, dual regulator
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// [RULE1] reset-cause bit 0 latches on analog supply undervoltage or soft reset
// [RULE2] reset cause disables regulators, defaults registers, reruns startup
// [RULE3] writing one clears reset-cause bit; writing zero leaves it set
// [RULE4] converter power-good events latch at bit 6 and bit 2
// [RULE5] converter short flags latch after output below threshold over 1 ms
// [RULE6] converter current-limit flags latch at bit 4 and bit 0
// [RULE7] linear regulator power-good events latch at bit 6 and bit 2
// [RULE8] linear regulator short flags latch after over 1 ms below threshold
// [RULE9] linear regulator current-limit flags latch at bit 4 and bit 0
// [RULE10] event flags clear individually by writing one, else stay latched
// [RULE11] live status bit 7 mirrors the power-good pin
// [RULE12] live status bit 4 is one while the external clock is invalid
// [RULE13] live status bit 3 is one above thermal shutdown level
// [RULE14] live status bit 2 is one above thermal warning level
// [RULE15] live status bit 1 is one above input overvoltage threshold
// [RULE16] converter summary flag drops when converter event register is zero
// [RULE17] regulator summary flag drops when regulator event register is zero
// [RULE18] soft reset request defaults registers, reloads, self-clears
// [RULE19] live status and reserved bits ignore writes; reserved read zero
// [RULE20] an event in the clear cycle keeps its flag set
module rev_event_status
   import rev_pkg::*;
#(
   parameter int SHORT_CYCLES = REV_SHORT_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // analog supply monitor
   input wire logic analog_supply_low,
   // regulator monitors, index 0 and 1
   input wire rev_reg_mon_t conv_mon [2],
   input wire rev_reg_mon_t linreg_mon [2],
   // live status sources
   input wire rev_live_t live_in,
   // host register port
   input wire rev_host_req_t host_req,
   output logic [7:0] host_rdata,
   output logic host_rvalid,
   // system control
   output logic regulators_disable,
   output logic startup_request,
   output logic nv_reload_request,
   output logic serial_if_reset,
   output logic conv_summary_flag,
   output logic linreg_summary_flag
);

   //////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic reset_cause;
      logic [7:0] conv_flags;
      logic [7:0] linreg_flags;
      logic [4:0] live_meta;
      logic [4:0] live_sync;
      logic [1:0][5:0] mon_meta;
      logic [1:0][5:0] mon_sync;
      logic supply_meta;
      logic supply_sync;
      logic [7:0] rdata;
      logic rvalid;
      logic reg_disable;
      logic startup;
      logic nv_reload;
      logic if_reset;
      logic conv_sum;
      logic linreg_sum;
   } rev_state_t;

   rev_state_t state;
   rev_state_t next_state;

   logic [1:0] conv_short_hit;
   logic [1:0] linreg_short_hit;
   logic soft_reset;
   logic reset_cause_event;
   logic [7:0] conv_set;
   logic [7:0] linreg_set;
   logic [7:0] conv_clr;
   logic [7:0] linreg_clr;
   logic [7:0] live_byte;
   logic [7:0] top_byte;

   //////////////////////////////////////////////////////////////////////////
   // short timers per channel
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ch
         rev_short_timer #(.CYCLES(SHORT_CYCLES)) u_conv_tmr (
            .core_clk(core_clk),
            .srst(srst),
            .below_threshold(state.mon_sync[gi][1]),
            .expired(conv_short_hit[gi])
         );
         rev_short_timer #(.CYCLES(SHORT_CYCLES)) u_linreg_tmr (
            .core_clk(core_clk),
            .srst(srst),
            .below_threshold(state.mon_sync[gi][4]),
            .expired(linreg_short_hit[gi])
         );
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      // input synchronisers
      next_state.supply_meta = analog_supply_low;
      next_state.supply_sync = state.supply_meta;
      next_state.live_meta = live_in;
      next_state.live_sync = state.live_meta;
      for (int i = 0; i < 2; i++) begin
         next_state.mon_meta[i] = {linreg_mon[i], conv_mon[i]};
         next_state.mon_sync[i] = state.mon_meta[i];
      end

      soft_reset = host_req.wr && host_req.addr == REV_ADDR_SOFTWARE_RESET_REQUEST &&
         host_req.wdata[0];
      reset_cause_event = state.supply_sync || soft_reset; // [RULE1]

      conv_set = 8'h00;
      linreg_set = 8'h00;
      conv_set[REV_BIT_CH0_POWER_GOOD] = state.mon_sync[0][2]; // [RULE4]
      conv_set[REV_BIT_CH1_POWER_GOOD] = state.mon_sync[1][2]; // [RULE4]
      conv_set[REV_BIT_CH0_SHORT] = conv_short_hit[0]; // [RULE5]
      conv_set[REV_BIT_CH1_SHORT] = conv_short_hit[1]; // [RULE5]
      conv_set[REV_BIT_CH0_CURRENT_LIMIT] = state.mon_sync[0][0]; // [RULE6]
      conv_set[REV_BIT_CH1_CURRENT_LIMIT] = state.mon_sync[1][0]; // [RULE6]
      linreg_set[REV_BIT_CH0_POWER_GOOD] = state.mon_sync[0][5]; // [RULE7]
      linreg_set[REV_BIT_CH1_POWER_GOOD] = state.mon_sync[1][5]; // [RULE7]
      linreg_set[REV_BIT_CH0_SHORT] = linreg_short_hit[0]; // [RULE8]
      linreg_set[REV_BIT_CH1_SHORT] = linreg_short_hit[1]; // [RULE8]
      linreg_set[REV_BIT_CH0_CURRENT_LIMIT] = state.mon_sync[0][3]; // [RULE9]
      linreg_set[REV_BIT_CH1_CURRENT_LIMIT] = state.mon_sync[1][3]; // [RULE9]

      // write-one clears, reserved bits masked off
      conv_clr = 8'h00;
      linreg_clr = 8'h00;
      if (host_req.wr && host_req.addr == REV_ADDR_CONV_EVENT) begin
         conv_clr = host_req.wdata & REV_EVENT_MASK; // [RULE10] [RULE19]
      end
      if (host_req.wr && host_req.addr == REV_ADDR_LINREG_EVENT) begin
         linreg_clr = host_req.wdata & REV_EVENT_MASK; // [RULE10] [RULE19]
      end

      // set wins over clear
      next_state.conv_flags = ((state.conv_flags & ~conv_clr) | conv_set) &
         REV_EVENT_MASK; // [RULE20]
      next_state.linreg_flags =
         ((state.linreg_flags & ~linreg_clr) | linreg_set) &
         REV_EVENT_MASK; // [RULE20]

      next_state.reset_cause = state.reset_cause;
      if (host_req.wr && host_req.addr == REV_ADDR_RESET_CAUSE &&
          host_req.wdata[REV_BIT_RESET_CAUSE]) begin
         next_state.reset_cause = 1'b0; // [RULE3]
      end

      // reset cause: other event flags back to defaults
      next_state.reg_disable = reset_cause_event; // [RULE2]
      next_state.startup = state.reg_disable && !reset_cause_event; // [RULE2]
      next_state.nv_reload = soft_reset; // [RULE18]
      next_state.if_reset = soft_reset; // [RULE18]
      if (reset_cause_event) begin
         next_state.conv_flags = REV_RESET_BYTE; // [RULE2] [RULE18]
         next_state.linreg_flags = REV_RESET_BYTE; // [RULE2] [RULE18]
         next_state.reset_cause = 1'b1; // [RULE1] [RULE20]
      end

      // summary flags follow the event registers
      next_state.conv_sum = |next_state.conv_flags; // [RULE16]
      next_state.linreg_sum = |next_state.linreg_flags; // [RULE17]

      // live status byte
      live_byte = 8'h00;
      live_byte[REV_BIT_POWER_GOOD_PIN] = state.live_sync[4]; // [RULE11]
      live_byte[REV_BIT_EXT_CLOCK_INVALID] = state.live_sync[3]; // [RULE12]
      live_byte[REV_BIT_THERMAL_SHUTDOWN] = state.live_sync[2]; // [RULE13]
      live_byte[REV_BIT_THERMAL_WARNING] = state.live_sync[1]; // [RULE14]
      live_byte[REV_BIT_INPUT_OVERVOLTAGE] = state.live_sync[0]; // [RULE15]

      top_byte = 8'h00;
      top_byte[REV_BIT_LINREG_SUMMARY] = state.linreg_sum;
      top_byte[REV_BIT_CONV_SUMMARY] = state.conv_sum;

      // read port, soft reset bit always reads zero
      next_state.rvalid = host_req.rd;
      next_state.rdata = 8'h00;
      if (host_req.rd) begin
         case (host_req.addr)
            REV_ADDR_RESET_CAUSE: begin
               next_state.rdata = {7'h00, state.reset_cause}; // [RULE19]
            end
            REV_ADDR_CONV_EVENT: begin
               next_state.rdata = state.conv_flags;
            end
            REV_ADDR_LINREG_EVENT: begin
               next_state.rdata = state.linreg_flags;
            end
            REV_ADDR_LIVE_STATUS: begin
               next_state.rdata = live_byte; // [RULE19]
            end
            REV_ADDR_TOP_SUMMARY: begin
               next_state.rdata = top_byte;
            end
            default: begin
               next_state.rdata = 8'h00;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   assign host_rdata = state.rdata;
   assign host_rvalid = state.rvalid;
   assign regulators_disable = state.reg_disable;
   assign startup_request = state.startup;
   assign nv_reload_request = state.nv_reload;
   assign serial_if_reset = state.if_reset;
   assign conv_summary_flag = state.conv_sum;
   assign linreg_summary_flag = state.linreg_sum;

endmodule : rev_event_status

// file: inc/rev_pkg.sv
// shared constants and types for the regulator event status block
package rev_pkg;

   // register addresses
   localparam logic [7:0] REV_ADDR_SOFTWARE_RESET_REQUEST = 8'h18;
   localparam logic [7:0] REV_ADDR_TOP_SUMMARY = 8'h19;
   localparam logic [7:0] REV_ADDR_RESET_CAUSE = 8'h1A;
   localparam logic [7:0] REV_ADDR_CONV_EVENT = 8'h1B;
   localparam logic [7:0] REV_ADDR_LINREG_EVENT = 8'h1C;
   localparam logic [7:0] REV_ADDR_LIVE_STATUS = 8'h1D;

   // event register field positions
   localparam int REV_BIT_RESET_CAUSE = 0;
   localparam int REV_BIT_CH0_CURRENT_LIMIT = 0;
   localparam int REV_BIT_CH0_SHORT = 1;
   localparam int REV_BIT_CH0_POWER_GOOD = 2;
   localparam int REV_BIT_CH1_CURRENT_LIMIT = 4;
   localparam int REV_BIT_CH1_SHORT = 5;
   localparam int REV_BIT_CH1_POWER_GOOD = 6;
   localparam logic [7:0] REV_EVENT_MASK = 8'h77;

   // live status field positions
   localparam int REV_BIT_INPUT_OVERVOLTAGE = 1;
   localparam int REV_BIT_THERMAL_WARNING = 2;
   localparam int REV_BIT_THERMAL_SHUTDOWN = 3;
   localparam int REV_BIT_EXT_CLOCK_INVALID = 4;
   localparam int REV_BIT_POWER_GOOD_PIN = 7;

   // summary flag positions at the top-level flag register
   localparam int REV_BIT_LINREG_SUMMARY = 6;
   localparam int REV_BIT_CONV_SUMMARY = 5;

   // values after reset
   localparam logic [7:0] REV_RESET_BYTE = 8'h00;

   // timing
   localparam int REV_CLK_HZ = 40_000_000;
   localparam int REV_SHORT_TIME_US = 1000;
   localparam int REV_SHORT_CYCLES =
      (REV_CLK_HZ / 1_000_000) * REV_SHORT_TIME_US + 1;
   localparam int REV_SHORT_CNT_W = 16;

   // raw detector inputs of one regulator
   typedef struct packed {
      logic power_good_event;
      logic below_short_threshold;
      logic current_limit_active;
   } rev_reg_mon_t;

   // live analog status inputs
   typedef struct packed {
      logic power_good_pin;
      logic external_clock_invalid;
      logic thermal_shutdown_state;
      logic thermal_warning_state;
      logic input_overvoltage_state;
   } rev_live_t;

   // host register port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rev_host_req_t;

endpackage : rev_pkg

// file: logic/rev_short_timer.sv
// short-circuit qualification timer for one regulator output
`timescale 1ns/1ps
module rev_short_timer
   import rev_pkg::*;
#(
   parameter int CYCLES = REV_SHORT_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // detector
   input wire logic below_threshold,
   output logic expired
);

   typedef struct packed {
      logic [REV_SHORT_CNT_W-1:0] count;
      logic expired;
   } rev_tmr_state_t;

   localparam logic [REV_SHORT_CNT_W-1:0] LIMIT =
      REV_SHORT_CNT_W'(CYCLES);

   rev_tmr_state_t state;
   rev_tmr_state_t next_state;

   always_comb begin
      next_state = state;
      next_state.expired = 1'b0;
      if (!below_threshold) begin
         next_state.count = '0;
      end else if (state.count < LIMIT) begin
         next_state.count = state.count + 1'b1;
      end else begin
         next_state.expired = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign expired = state.expired;

endmodule : rev_short_timer

// file: tb/rev_host_model.sv
// host side model driving the register port of the event block
`timescale 1ns/1ps
module rev_host_model
   import rev_pkg::*;
(
   // clock
   input wire logic core_clk,
   // register port
   output rev_host_req_t host_req,
   input wire logic [7:0] host_rdata,
   input wire logic host_rvalid
);
   initial host_req = '0;
   ////////////////////////////////////////////////////////////////////////
   // one-cycle request; idle fields show inverted values
   task automatic put(input logic w, input logic [7:0] a,
      input logic [7:0] d);
      @(negedge core_clk);
      host_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge core_clk);
      @(negedge core_clk);
      host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : put
   // single register write, used for write-one clears, soft reset and ignored writes
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      put(1'b1, a, d);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
      output logic ok);
      put(1'b0, a, 8'h00);
      ok = host_rvalid;
      d = host_rdata;
   endtask : rd_reg
endmodule : rev_host_model

// file: tb/rev_event_status_assertions.sv
// port checks of the event status block
`timescale 1ns/1ps
module rev_event_status_checker
   import rev_pkg::*;
#(
   parameter int SHORT_CYCLES = REV_SHORT_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // monitors
   input wire logic analog_supply_low,
   input wire rev_reg_mon_t conv_mon [2],
   input wire rev_reg_mon_t linreg_mon [2],
   input wire rev_live_t live_in,
   // host port
   input wire rev_host_req_t host_req,
   input wire logic [7:0] host_rdata,
   input wire logic host_rvalid,
   // system control
   input wire logic regulators_disable,
   input wire logic startup_request,
   input wire logic nv_reload_request,
   input wire logic serial_if_reset,
   input wire logic conv_summary_flag,
   input wire logic linreg_summary_flag
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   logic sw_rst;
   assign sw_rst = host_req.wr && host_req.addr == REV_ADDR_SOFTWARE_RESET_REQUEST &&
      host_req.wdata[0];
   ////////////////////////////////////////////////////////////////////////
   a_read_answer:
      assert property (host_req.rd |=> host_rvalid)
      else $error("read not answered next cycle");
   a_idle_rdata_zero:
      assert property (!host_rvalid |-> host_rdata == 8'h00)
      else $error("read data not zero while idle");
   a_live_reserved:
      assert property (host_rvalid && $past(host_req.addr) == 8'h1D
         |-> host_rdata[6:5] == 2'b00 && !host_rdata[0])
      else $error("live status reserved bit set");
   a_event_reserved:
      assert property (host_rvalid && $past(host_req.addr) inside
         {8'h1B, 8'h1C} |-> (host_rdata & ~REV_EVENT_MASK) == 8'h00)
      else $error("event reserved bit set");
   a_unmapped_zero:
      assert property (host_rvalid && !($past(host_req.addr) inside
         {[8'h18:8'h1D]}) |-> host_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_soft_reset_pulse:
      assert property (sw_rst |=> nv_reload_request && serial_if_reset
         && regulators_disable)
      else $error("soft reset pulses missing");
   a_startup_follow:
      assert property ($fell(regulators_disable) |-> startup_request)
      else $error("startup not requested after disable");
   a_conv_summary:
      assert property (host_rvalid && $past(host_req.addr) == 8'h1B
         |-> $past(conv_summary_flag) == (host_rdata != 8'h00))
      else $error("converter summary disagrees with register");
   a_linreg_summary:
      assert property (host_rvalid && $past(host_req.addr) == 8'h1C
         |-> $past(linreg_summary_flag) == (host_rdata != 8'h00))
      else $error("regulator summary disagrees with register");
   a_limit_latch:
      assert property (conv_mon[0].current_limit_active [*3]
         |=> conv_summary_flag)
      else $error("current limit not latched");
endmodule : rev_event_status_checker
bind rev_event_status rev_event_status_checker #(
   .SHORT_CYCLES(SHORT_CYCLES)
) i_checker (.core_clk(core_clk), .srst(srst),
   .analog_supply_low(analog_supply_low), .conv_mon(conv_mon),
   .linreg_mon(linreg_mon), .live_in(live_in), .host_req(host_req),
   .host_rdata(host_rdata), .host_rvalid(host_rvalid),
   .regulators_disable(regulators_disable),
   .startup_request(startup_request),
   .nv_reload_request(nv_reload_request),
   .serial_if_reset(serial_if_reset),
   .conv_summary_flag(conv_summary_flag),
   .linreg_summary_flag(linreg_summary_flag));

// file: tb/tb_top.sv
// self-checking bench of the event status block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_top
   import rev_pkg::*;
;
   localparam int SC = 5;
   logic core_clk;
   logic srst;
   logic analog_supply_low;
   rev_reg_mon_t conv_mon [2];
   rev_reg_mon_t linreg_mon [2];
   rev_live_t live_in;
   rev_host_req_t host_req;
   logic [7:0] host_rdata;
   logic host_rvalid;
   logic regulators_disable, startup_request, nv_reload_request;
   logic serial_if_reset, conv_summary_flag, linreg_summary_flag;
   int failures = 0;
   int n_compared = 0;
   logic [7:0] ev [2];
   ////////////////////////////////////////////////////////////////////////
   rev_event_status #(.SHORT_CYCLES(SC)) i_dut (.core_clk(core_clk),
      .srst(srst), .analog_supply_low(analog_supply_low),
      .conv_mon(conv_mon), .linreg_mon(linreg_mon), .live_in(live_in),
      .host_req(host_req), .host_rdata(host_rdata),
      .host_rvalid(host_rvalid), .regulators_disable(regulators_disable),
      .startup_request(startup_request),
      .nv_reload_request(nv_reload_request),
      .serial_if_reset(serial_if_reset),
      .conv_summary_flag(conv_summary_flag),
      .linreg_summary_flag(linreg_summary_flag));
   rev_host_model i_host (.core_clk(core_clk), .host_req(host_req),
      .host_rdata(host_rdata), .host_rvalid(host_rvalid));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] exp_live(input rev_live_t l);
      return {l.power_good_pin, 2'b00, l.external_clock_invalid,
         l.thermal_shutdown_state, l.thermal_warning_state,
         l.input_overvoltage_state, 1'b0};
   endfunction : exp_live
   function automatic logic [7:0] ea(input int g);
      return g ? REV_ADDR_LINREG_EVENT : REV_ADDR_CONV_EVENT;
   endfunction : ea
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      i_host.rd_reg(a, d, ok);
      `CHK(ok, 1'b1)
      `CHK(d, e)
   endtask : chk_rd
   task automatic drive(input int g, input int ch, input logic [2:0] v,
      input int n);
      if (g == 0) conv_mon[ch] = v;
      else linreg_mon[ch] = v;
      repeat (n) @(negedge core_clk);
      if (g == 0) conv_mon[ch] = '0;
      else linreg_mon[ch] = '0;
      repeat (4) @(negedge core_clk);
   endtask : drive
   task automatic final_report();
      if (failures == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      final_report();
   end
   initial begin
      int g, k;
      rev_live_t lv;
      srst = 1'b1;
      analog_supply_low = 1'b0;
      conv_mon = '{default: '0};
      linreg_mon = '{default: '0};
      live_in = '0;
      ev = '{default: '0};
      void'($urandom(69));
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      srst = 1'b0;
      for (int a = 8'h18; a <= 8'h1E; a++) begin
         chk_rd(8'(a), 8'h00);
      end
      repeat (8) begin
         lv = 5'($urandom);
         live_in = lv;
         repeat (3) @(negedge core_clk);
         i_host.wr_reg(REV_ADDR_LIVE_STATUS, 8'hFF);
         chk_rd(8'h1D, exp_live(lv));
         chk_rd(8'h1D, exp_live(lv));
      end
      for (int i = 0; i < 12; i++) begin
         g = i / 6;
         k = i % 3;
         if (k == 1) begin
            drive(g, (i / 3) % 2, 3'b010, 2);
            chk_rd(ea(g), ev[g]);
         end
         drive(g, (i / 3) % 2, 3'(1 << k), k == 1 ? SC + 6 : 1 + $urandom % 3);
         ev[g][((i / 3) % 2) * 4 + k] = 1'b1;
         chk_rd(ea(g), ev[g]);
         chk_rd(ea(g), ev[g]);
      end
      chk_rd(REV_ADDR_TOP_SUMMARY, 8'h60);
      for (int i = 0; i < 16; i++) begin
         g = i / 8;
         i_host.wr_reg(ea(g), 8'h00);
         i_host.wr_reg(ea(g), 8'h01 << (i % 8));
         ev[g][i % 8] = 1'b0;
         chk_rd(ea(g), ev[g]);
      end
      `CHK({conv_summary_flag, linreg_summary_flag}, 2'b00)
      conv_mon[0] = 3'b001;
      repeat (4) @(negedge core_clk);
      i_host.wr_reg(ea(0), 8'h01);
      chk_rd(ea(0), 8'h01);
      conv_mon[0] = 3'b000;
      repeat (4) @(negedge core_clk);
      i_host.wr_reg(ea(0), 8'h01);
      chk_rd(ea(0), 8'h00);
      drive(1, 1, 3'b100, 1);
      i_host.wr_reg(REV_ADDR_SOFTWARE_RESET_REQUEST, 8'h01);
      `CHK({regulators_disable, startup_request}, 2'b10)
      `CHK({nv_reload_request, serial_if_reset}, 2'b11)
      @(negedge core_clk);
      `CHK({regulators_disable, startup_request}, 2'b01)
      `CHK({nv_reload_request, serial_if_reset}, 2'b00)
      chk_rd(ea(1), 8'h00);
      chk_rd(REV_ADDR_SOFTWARE_RESET_REQUEST, 8'h00);
      for (int v = 0; v < 2; v++) begin
         chk_rd(REV_ADDR_RESET_CAUSE, 8'h01);
         i_host.wr_reg(REV_ADDR_RESET_CAUSE, 8'(v));
      end
      chk_rd(REV_ADDR_RESET_CAUSE, 8'h00);
      analog_supply_low = 1'b1;
      repeat (3) @(negedge core_clk);
      analog_supply_low = 1'b0;
      repeat (6) @(negedge core_clk);
      chk_rd(REV_ADDR_RESET_CAUSE, 8'h01);
      final_report();
   end
endmodule : tb_top
